// ===== core/field_sensor_output_config.sv
// Configuration decode, processing path and output conditioning of the field sensor
//
// What this block does
// R01: Ten-bit config word, documented field positions
// R02: Range decode from bit 9 and bits 2:1
// R03: Reduced variant lacks the 15 mT range
// R04: Filter cut-off decode from bits 4:3
// R05: Output format decode from bits 7:5
// R06: Reduced variant offers analog format only
// R07: Analog format drives 12-bit ratiometric level
// R08: Multiplex splits 14 bits into two 7-bit parts
// R09: Trigger mode: pull-up high part, refresh 2 ms
// R10: Continuous multiplex sends low then high part
// R11: Burn-in drives internal sawtooth through path
// R12: PWM 11-bit duty, 8 ms period
// R13: Duty updates at rising edge; inverted complements
// R14: Host samples duty at falling edge
// R15: Temperature coefficient group code mapping
// R16: Slope 5 bits, curvature 3 bits
// R17: Signed gain factor from -4 to 4
// R18: Offset added; negative offset lowers maximum
// R19: Lower clamp up to half supply
// R20: Upper clamp up to full supply
// R21: Four 13-bit user blocks, three preloaded
// R22: Programmer accesses user blocks in order
// R23: Multiply by gain, add offset, then clamp
// R24: 14-bit readout, zero outside analog format
// R25: Programmer writes zero to reserved bits
`default_nettype none
module field_sensor_output_config
  import field_sensor_pkg::*;
#(
  parameter bit          REDUCED_VARIANT = 1'b0,
  parameter int          PWM_PERIOD      = PWM_PERIOD_CYC,
  parameter int          MUX_REFRESH     = MUX_REFRESH_CYC,
  // Preloaded user data; values are arbitrary
  parameter logic [12:0] USER_INIT0      = 13'h0001,
  parameter logic [12:0] USER_INIT1      = 13'h0002,
  parameter logic [12:0] USER_INIT2      = 13'h0003
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_field_valid,
  input  wire logic [13:0]       i_field_value,
  output logic                   o_field_ready,
  input  wire logic              i_prog_we,
  input  wire logic              i_prog_re,
  input  wire logic [3:0]        i_prog_addr,
  input  wire logic [15:0]       i_prog_wdata,
  output logic [15:0]            o_prog_rdata,
  output logic                   o_prog_rvalid,
  input  wire logic              i_pin_pulled_up,
  output logic                   o_pin_oe_n,
  output logic [11:0]            o_dac_code,
  output logic                   o_pwm_level,
  output range_t                 o_range_sel,
  output filter_t                o_filter_sel,
  output logic [1:0]             o_temp_coeff_group,
  output logic [4:0]             o_temp_slope_coeff,
  output logic [2:0]             o_temp_curve_coeff
);
  localparam logic [20:0] PER     = 21'(PWM_PERIOD);
  localparam logic [20:0] PER_M1  = 21'(PWM_PERIOD - 1);
  localparam logic [20:0] REFR_M1 = 21'(MUX_REFRESH - 1);

  // Parameter registers
  logic [9:0]  sensor_config_word;
  logic [1:0]  temp_coeff_group;
  logic [4:0]  temp_slope_coeff;
  logic [2:0]  temp_curve_coeff;
  logic [13:0] gain;
  logic [11:0] quiescent_offset;
  logic [8:0]  clamp_lo;
  logic [8:0]  clamp_hi;
  logic [12:0] user_info_store [4];

  // Output stage state
  mux_state_t  state;
  logic [20:0] timer;
  logic [13:0] held;
  logic [20:0] pwm_thr;
  logic [13:0] saw;
  logic        pin_meta;
  logic        pin_up;

  // R01: field extraction
  wire [2:0] output_format_select = sensor_config_word[FMT_LSB +: 3];
  wire [1:0] filt_bits  = sensor_config_word[FILT_LSB +: 2];
  wire [1:0] range_bits = sensor_config_word[RANGE_LSB +: 2];
  wire       range_hi   = sensor_config_word[BIT_RANGE_HI];

  wire cfg_wr = i_prog_we && (i_prog_addr == IDX_CONFIG);

  // R06: reduced variant stores analog format only
  wire [9:0] cfg_masked = i_prog_wdata[9:0] & CFG_KEEP_MASK;
  wire [9:0] cfg_fmt_fixed = REDUCED_VARIANT ? {cfg_masked[9:8], FMT_ANALOG, cfg_masked[4:0]} : cfg_masked;
  // R03: 15 mT code falls back to 30 mT on the reduced variant
  wire       drop_15 = REDUCED_VARIANT && (cfg_fmt_fixed[RANGE_LSB +: 2] == 2'b00);
  wire [9:0] next_config = drop_15 ? {1'b0, cfg_fmt_fixed[8:0]} : cfg_fmt_fixed;

  // R05: format decode
  wire is_analog = (output_format_select == FMT_ANALOG);
  wire is_burn   = (output_format_select == FMT_BURN);
  wire is_cont   = (output_format_select == FMT_MUX_CONT);
  wire is_trig   = (output_format_select == FMT_MUX_TRIG);
  wire is_pwm    = (output_format_select == FMT_PWM) || (output_format_select == FMT_PWM_INV);
  wire is_inv    = (output_format_select == FMT_PWM_INV);

  // R02: range decode
  wire [2:0] range_key = {range_hi, range_bits};
  range_t next_range;
  always_comb begin
    unique case (range_key)
      3'b100:  next_range = RNG_15;
      3'b110:  next_range = RNG_40;
      3'b001:  next_range = RNG_60;
      3'b010:  next_range = RNG_80;
      3'b011:  next_range = RNG_100;
      3'b111:  next_range = RNG_150;
      // Undefined 1/01 treated as 30 mT, like 0/00
      default: next_range = RNG_30;
    endcase
  end

  // R04: filter decode
  filter_t next_filter;
  always_comb begin
    unique case (filt_bits)
      2'b00: next_filter = FLT_80HZ;
      2'b10: next_filter = FLT_500HZ;
      2'b11: next_filter = FLT_1KHZ;
      2'b01: next_filter = FLT_2KHZ;
    endcase
  end

  // R11: burn-in replaces the field with an internal ramp
  wire signed [13:0] stim = is_burn ? $signed(saw) : $signed(i_field_value);
  // R17: signed gain in 1/2048 steps
  wire signed [27:0] prod   = stim * $signed(gain);
  wire signed [17:0] scaled = {prod[27], prod[27:GAIN_FRAC]};
  // R18: offset counts 16 output codes per step
  wire signed [17:0] off16  = {{2{quiescent_offset[11]}}, quiescent_offset, 4'h0};
  // R23: multiply, add, then limit
  wire signed [17:0] sum    = scaled + off16;
  wire signed [17:0] full_s = 18'sh03fff;
  wire signed [17:0] cap_s  = quiescent_offset[11] ? full_s + off16 : full_s;
  // R20: upper clamp, 32 codes per step
  wire signed [17:0] hi_s   = $signed({4'h0, clamp_hi, 5'h1f});
  // R19: lower clamp
  wire signed [17:0] lo_s   = $signed({4'h0, clamp_lo, 5'h00});
  wire signed [17:0] top_s  = (cap_s < hi_s) ? cap_s : hi_s;
  wire signed [17:0] lim_s  = (sum > top_s) ? top_s : sum;
  wire signed [17:0] res_s  = (lim_s < lo_s) ? lo_s : lim_s;
  wire [13:0] next_value = res_s[13:0];

  // Buffer hookup
  wire        buf_in_valid = is_burn || i_field_valid;
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [13:0] buf_out_data;
  wire        timer_zero = (timer == 21'h0);
  // PWM and multiplex formats stall the drain until their output slot opens; analog and burn-in drain at once
  wire drain_ready = is_pwm  ? timer_zero :
                     is_trig ? timer_zero :
                     is_cont ? (state == ST_IDLE) : 1'b1;
  wire take = buf_out_valid && drain_ready;

  assign o_field_ready = buf_in_ready;

  value_skid_buffer #(.W(VALUE_W)) u_buf (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (next_value),
    .o_out_valid (buf_out_valid),
    .i_out_ready (drain_ready),
    .o_out_data  (buf_out_data)
  );

  // R12: 11-bit duty scaled onto the period
  wire [10:0] duty     = buf_out_data[13:3];
  wire [31:0] thr_prod = 32'(duty) * 32'(PER);
  wire [20:0] thr_norm = thr_prod[31:11];
  // R13: inverted duty is the complement
  wire [20:0] next_thr = is_inv ? PER - thr_norm : thr_norm;
  wire [20:0] elapsed  = PER_M1 - timer;

  // R08: the two 7-bit parts
  wire [6:0] low_nibble_part  = held[6:0];
  wire [6:0] high_nibble_part = held[13:7];

  // R24: readout reads zero outside analog format
  wire [13:0] readout = is_analog ? held : 14'h0000;
  wire [1:0]  user_idx = i_prog_addr[1:0];
  wire [15:0] next_rdata =
    (i_prog_addr == IDX_CONFIG)   ? {6'h00, sensor_config_word} :
    (i_prog_addr == IDX_TC_GROUP) ? {14'h0000, temp_coeff_group} :
    (i_prog_addr == IDX_SLOPE)    ? {11'h000, temp_slope_coeff} :
    (i_prog_addr == IDX_CURVE)    ? {13'h0000, temp_curve_coeff} :
    (i_prog_addr == IDX_GAIN)     ? {2'h0, gain} :
    (i_prog_addr == IDX_OFFSET)   ? {4'h0, quiescent_offset} :
    (i_prog_addr == IDX_CLAMP_LO) ? {7'h00, clamp_lo} :
    (i_prog_addr == IDX_CLAMP_HI) ? {7'h00, clamp_hi} :
    (i_prog_addr[3:2] == 2'b10)   ? {3'h0, user_info_store[user_idx]} :
    (i_prog_addr == IDX_READOUT)  ? {2'h0, readout} : 16'h0000;

  // Lower clamp cannot pass half supply
  wire [8:0] next_clamp_lo = (i_prog_wdata[8:0] > CLAMP_LO_MAX) ? CLAMP_LO_MAX : i_prog_wdata[8:0];

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sensor_config_word <= CFG_RST;
      temp_coeff_group   <= TC_GROUP_RST;
      temp_slope_coeff   <= '0;
      temp_curve_coeff   <= '0;
      gain               <= GAIN_RST;
      quiescent_offset   <= OFFSET_RST;
      clamp_lo           <= CLAMP_LO_RST;
      clamp_hi           <= CLAMP_HI_RST;
      user_info_store[0] <= USER_INIT0;
      user_info_store[1] <= USER_INIT1;
      user_info_store[2] <= USER_INIT2;
      user_info_store[3] <= '0;
    end else if (i_prog_we) begin
      // R01: reserved bits kept at zero
      if (cfg_wr) sensor_config_word <= next_config;
      // R15: group code stored as coded
      if (i_prog_addr == IDX_TC_GROUP) temp_coeff_group <= i_prog_wdata[1:0];
      // R16: slope and curvature widths
      if (i_prog_addr == IDX_SLOPE) temp_slope_coeff <= i_prog_wdata[4:0];
      if (i_prog_addr == IDX_CURVE) temp_curve_coeff <= i_prog_wdata[2:0];
      if (i_prog_addr == IDX_GAIN) gain <= i_prog_wdata[13:0];
      if (i_prog_addr == IDX_OFFSET) quiescent_offset <= i_prog_wdata[11:0];
      if (i_prog_addr == IDX_CLAMP_LO) clamp_lo <= next_clamp_lo;
      if (i_prog_addr == IDX_CLAMP_HI) clamp_hi <= i_prog_wdata[8:0];
      // R21: four 13-bit user blocks
      if (i_prog_addr[3:2] == 2'b10) user_info_store[user_idx] <= i_prog_wdata[12:0];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prog_rdata  <= 16'h0000;
      o_prog_rvalid <= 1'b0;
    end else begin
      o_prog_rdata  <= i_prog_re ? next_rdata : o_prog_rdata;
      o_prog_rvalid <= i_prog_re;
    end
  end

  // Decoded settings toward the converter, filter and compensation
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_range_sel        <= RNG_30;
      o_filter_sel       <= FLT_80HZ;
      o_temp_coeff_group <= TC_GROUP_RST;
      o_temp_slope_coeff <= '0;
      o_temp_curve_coeff <= '0;
      o_pin_oe_n         <= 1'b1;
    end else begin
      o_range_sel        <= next_range;
      o_filter_sel       <= next_filter;
      o_temp_coeff_group <= temp_coeff_group;
      o_temp_slope_coeff <= temp_slope_coeff;
      o_temp_curve_coeff <= temp_curve_coeff;
      o_pin_oe_n         <= 1'b0;
    end
  end

  // Pull direction arrives from the pin
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta <= 1'b0;
      pin_up   <= 1'b0;
    end else begin
      pin_meta <= i_pin_pulled_up;
      pin_up   <= pin_meta;
    end
  end

  // R11: ramp advances with each accepted sample
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) saw <= 14'h0000;
    else if (is_burn && buf_in_ready) saw <= saw + 14'h0001;
  end

  // Shared timer: PWM period, multiplex dwell or refresh guard
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      timer <= 21'h0;
      held  <= 14'h0000;
    end else if (cfg_wr) begin
      // A word drained on the config edge must still land
      if (take) held <= buf_out_data;
      state <= ST_IDLE;
      timer <= 21'h0;
    end else begin
      if (take) held <= buf_out_data;
      if (is_pwm) begin
        // R12: period restarts at the rising edge
        timer <= timer_zero ? PER_M1 : timer - 21'h1;
      end else if (is_trig) begin
        // R09: one refresh per guard interval
        timer <= take ? REFR_M1 : (timer_zero ? timer : timer - 21'h1);
      end else if (is_cont) begin
        // R10: low part, then high part, then next sample
        unique case (state)
          ST_IDLE: if (take) begin
            state <= ST_LOW;
            timer <= REFR_M1;
          end
          ST_LOW: if (timer_zero) begin
            state <= ST_HIGH;
            timer <= REFR_M1;
          end else timer <= timer - 21'h1;
          ST_HIGH: if (timer_zero) state <= ST_IDLE;
            else timer <= timer - 21'h1;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) pwm_thr <= 21'h0;
    // R13: duty changes only at the period start
    else if (take && is_pwm) pwm_thr <= next_thr;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dac_code  <= 12'h000;
      o_pwm_level <= 1'b0;
    end else begin
      o_pwm_level <= is_pwm && (elapsed < pwm_thr);
      // R09: pull-up selects the high part
      if (is_trig) o_dac_code <= {pin_up ? high_nibble_part : low_nibble_part, 5'h00};
      // R08: each part sent as a 7-bit level
      else if (is_cont && state == ST_LOW) o_dac_code <= {low_nibble_part, 5'h00};
      else if (is_cont && state == ST_HIGH) o_dac_code <= {high_nibble_part, 5'h00};
      // R07: 12-bit level from the 14-bit value
      else if ((is_analog || is_burn) && take) o_dac_code <= buf_out_data[13:2];
      else if (is_pwm) o_dac_code <= 12'h000;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_range_thirty: assert property ( // R02
    !cfg_wr && range_key == 3'b000 |=> o_range_sel == RNG_30)
    else $error("range 0/00 not decoded as 30 mT");

  a_no_fifteen: assert property ( // R03
    REDUCED_VARIANT |-> o_range_sel != RNG_15)
    else $error("15 mT range on reduced variant");

  a_analog_only: assert property ( // R06
    REDUCED_VARIANT |-> output_format_select == FMT_ANALOG)
    else $error("non-analog format on reduced variant");

  a_analog_level: assert property ( // R07
    is_analog && take && !cfg_wr |=> o_dac_code == $past(buf_out_data[13:2]))
    else $error("analog level not taken from value");

  a_cont_order: assert property ( // R10
    is_cont && !cfg_wr && state == ST_LOW && timer_zero |=> state == ST_HIGH ##1 o_dac_code == {held[13:7], 5'h00})
    else $error("high part does not follow low part");

  a_duty_edge: assert property ( // R13
    is_pwm && !$past(cfg_wr) && pwm_thr != $past(pwm_thr) |-> $past(timer) == 21'h0)
    else $error("duty changed away from period start");

  a_clamp_window: assert property ( // R23
    buf_in_valid && buf_in_ready |-> res_s >= lo_s && res_s <= top_s || lo_s > top_s)
    else $error("value outside clamp window");

  a_readout_zero: assert property ( // R24
    i_prog_re && i_prog_addr == IDX_READOUT && !is_analog |=> o_prog_rdata == 16'h0000)
    else $error("readout not zero outside analog format");

  a_lo_clamp_max: assert property ( // R19
    clamp_lo <= CLAMP_LO_MAX)
    else $error("lower clamp above half supply");
endmodule : field_sensor_output_config
`default_nettype wire

// ===== include/field_sensor_pkg.sv
// Shared constants and types for the field sensor output configuration block
`default_nettype none
package field_sensor_pkg;
  // Configuration word layout
  localparam int         CFG_W         = 10;
  localparam int         BIT_RANGE_HI  = 9;
  localparam int         FMT_LSB       = 5;
  localparam int         FILT_LSB      = 3;
  localparam int         RANGE_LSB     = 1;
  localparam logic [9:0] CFG_KEEP_MASK = 10'h2fe;
  localparam logic [9:0] CFG_RST       = 10'h000;

  // Output format codes
  localparam logic [2:0] FMT_ANALOG   = 3'h0;
  localparam logic [2:0] FMT_MUX_CONT = 3'h1;
  localparam logic [2:0] FMT_BURN     = 3'h2;
  localparam logic [2:0] FMT_MUX_TRIG = 3'h3;
  localparam logic [2:0] FMT_PWM      = 3'h6;
  localparam logic [2:0] FMT_PWM_INV  = 3'h7;

  // Register indices on the programming port
  localparam int         ADDR_W       = 4;
  localparam logic [3:0] IDX_CONFIG   = 4'h0;
  localparam logic [3:0] IDX_TC_GROUP = 4'h1;
  localparam logic [3:0] IDX_SLOPE    = 4'h2;
  localparam logic [3:0] IDX_CURVE    = 4'h3;
  localparam logic [3:0] IDX_GAIN     = 4'h4;
  localparam logic [3:0] IDX_OFFSET   = 4'h5;
  localparam logic [3:0] IDX_CLAMP_LO = 4'h6;
  localparam logic [3:0] IDX_CLAMP_HI = 4'h7;
  localparam logic [3:0] IDX_USER0    = 4'h8;
  localparam logic [3:0] IDX_READOUT  = 4'hc;

  // Widths
  localparam int DATA_W   = 16;
  localparam int VALUE_W  = 14;
  localparam int DAC_W    = 12;
  localparam int PART_W   = 7;
  localparam int DUTY_W   = 11;
  localparam int GAIN_W   = 14;
  localparam int GAIN_FRAC = 11;
  localparam int OFFSET_W = 12;
  localparam int CLAMP_W  = 9;
  localparam int USER_W   = 13;
  localparam int SLOPE_W  = 5;
  localparam int CURVE_W  = 3;
  localparam int TMR_W    = 21;

  // Reset values
  localparam logic [1:0]  TC_GROUP_RST = 2'h1;
  localparam logic [13:0] GAIN_RST     = 14'h0800;
  localparam logic [11:0] OFFSET_RST   = 12'h200;
  localparam logic [8:0]  CLAMP_LO_RST = 9'h000;
  localparam logic [8:0]  CLAMP_HI_RST = 9'h1ff;
  localparam logic [8:0]  CLAMP_LO_MAX = 9'h100;

  // Timing
  localparam int CLK_MHZ         = 250;
  localparam int PWM_PERIOD_MS   = 8;
  localparam int PWM_PERIOD_CYC  = PWM_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int MUX_REFRESH_MS  = 2;
  localparam int MUX_REFRESH_CYC = MUX_REFRESH_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    RNG_15, RNG_30, RNG_40, RNG_60, RNG_80, RNG_100, RNG_150
  } range_t;

  typedef enum logic [1:0] {FLT_80HZ, FLT_500HZ, FLT_1KHZ, FLT_2KHZ} filter_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11} mux_state_t;
endpackage : field_sensor_pkg
`default_nettype wire

// ===== core/value_skid_buffer.sv
// Two-entry buffer between the processing path and the output stage
`default_nettype none
module value_skid_buffer #(
  parameter int W = 14
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  logic [W-1:0] entry [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;

  wire push = i_in_valid && o_in_ready;
  wire pop  = o_out_valid && i_out_ready;
  wire [1:0] next_count = 2'(count + {1'b0, push} - {1'b0, pop});

  assign o_out_valid = (count != 2'h0);
  assign o_out_data  = entry[rd_ptr];

  always_ff @(posedge i_clk_sys) begin
    if (push) entry[wr_ptr] <= i_in_data;
  end

  // Ready is registered so the source never sees a combinational path
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
      o_in_ready <= 1'b0;
    end else begin
      wr_ptr     <= wr_ptr ^ push;
      rd_ptr     <= rd_ptr ^ pop;
      count      <= next_count;
      o_in_ready <= (next_count != 2'h2);
    end
  end
endmodule : value_skid_buffer
`default_nettype wire

// ===== dv/host_unit_model.sv
// Host unit model: sets the pin pull and measures the PWM output
`default_nettype none
module host_unit_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_pwm_level,
  input  wire logic i_want_high,
  output logic      o_pin_pulled_up,
  output int        o_high_time,
  output int        o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  int   cnt_hi;
  int   cnt_per;
  assign o_pin_pulled_up = i_want_high;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last        <= 1'b0;
      cnt_hi      <= 0;
      cnt_per     <= 0;
      o_high_time <= 0;
      o_period    <= 0;
    end else begin
      last <= i_pwm_level;
      if (i_pwm_level && !last) begin
        o_period <= cnt_per;
        cnt_per  <= 1;
        cnt_hi   <= 1;
      end else begin
        cnt_per <= cnt_per + 1;
        if (i_pwm_level) cnt_hi <= cnt_hi + 1;
      end
      if (!i_pwm_level && last) o_high_time <= cnt_hi;
    end
  end
endmodule : host_unit_model
`default_nettype wire

// ===== dv/field_sensor_output_config_bench.sv
// Self-checking bench for the field sensor output configuration block
`default_nettype none
module field_sensor_output_config_bench
  import field_sensor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run small
  localparam int PER = 4096;
  localparam int REF = 16;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fv = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        want_hi = 1'b0;
  logic        pin_up;
  logic [13:0] fval = '0;
  logic [3:0]  addr = '0;
  logic [15:0] wdata = '0;
  logic        f_rdy;
  logic        rvalid;
  logic        oe_n;
  logic        pwm;
  logic [15:0] rdata;
  logic [11:0] dac;
  range_t      rng;
  range_t      rng_s;
  filter_t     flt;
  logic [1:0]  grp;
  logic [4:0]  slope;
  logic [2:0]  curve;
  int          hi_t;
  int          per_t;
  int          wt;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [15:0] got;
  logic [9:0]  cfg;
  logic [13:0] e;
  logic [13:0] f;
  logic [13:0] g;
  logic [11:0] o;
  logic [8:0]  lo;
  logic [8:0]  hi;
  logic [15:0] rst_exp [14] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0800, 16'h0200, 16'h0000,
                                16'h01ff, 16'h0001, 16'h0002, 16'h0003, 16'h0000, 16'h0000, 16'h0000};

  always #2 clk = ~clk;

  field_sensor_output_config #(.PWM_PERIOD(PER), .MUX_REFRESH(REF)) dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_field_valid(fv), .i_field_value(fval), .o_field_ready(f_rdy),
    .i_prog_we(we), .i_prog_re(re), .i_prog_addr(addr), .i_prog_wdata(wdata), .o_prog_rdata(rdata),
    .o_prog_rvalid(rvalid), .i_pin_pulled_up(pin_up), .o_pin_oe_n(oe_n), .o_dac_code(dac),
    .o_pwm_level(pwm), .o_range_sel(rng), .o_filter_sel(flt), .o_temp_coeff_group(grp),
    .o_temp_slope_coeff(slope), .o_temp_curve_coeff(curve));

  host_unit_model partner (.i_clk_sys(clk), .i_sys_rst(rst), .i_pwm_level(pwm), .i_want_high(want_hi),
    .o_pin_pulled_up(pin_up), .o_high_time(hi_t), .o_period(per_t));

  field_sensor_output_config #(.REDUCED_VARIANT(1'b1)) dut_small (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_field_valid(fv), .i_field_value(fval), .o_field_ready(),
    .i_prog_we(we), .i_prog_re(re), .i_prog_addr(addr), .i_prog_wdata(wdata), .o_prog_rdata(),
    .o_prog_rvalid(), .i_pin_pulled_up(pin_up), .o_pin_oe_n(), .o_dac_code(), .o_pwm_level(),
    .o_range_sel(rng_s), .o_filter_sel(), .o_temp_coeff_group(), .o_temp_slope_coeff(),
    .o_temp_curve_coeff());

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
    n_compared++;
    if (sn !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask : wr

  task rd(input logic [3:0] a);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    got = rdata;
    @(negedge clk);
  endtask : rd

  task send(input logic [13:0] v);
    fval = v;
    fv = 1'b1;
    for (int k = 0; k < 100 && f_rdy !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    fv = 1'b0;
  endtask : send

  // Clamp order: upper first, then forced up to lower
  function automatic logic [13:0] proc(input logic signed [13:0] fi, input logic signed [13:0] gi,
                                       input logic signed [11:0] oi, input logic [8:0] l, input logic [8:0] h);
    int p;
    int up;
    int lw;
    p = ((fi * gi) >>> 11) + oi * 16;
    up = int'(h) * 32 + 31;
    lw = int'(l) * 32;
    if (oi < 0 && 16383 + oi * 16 < up) up = 16383 + oi * 16;
    if (p > up) p = up;
    if (p < lw) p = lw;
    return p[13:0];
  endfunction : proc

  function automatic range_t exp_rng(input logic [9:0] c);
    case ({c[9], c[2:1]})
      3'h4: return RNG_15;
      3'h6: return RNG_40;
      3'h1: return RNG_60;
      3'h2: return RNG_80;
      3'h3: return RNG_100;
      3'h7: return RNG_150;
      default: return RNG_30;
    endcase
  endfunction : exp_rng

  function automatic filter_t exp_flt(input logic [9:0] c);
    case (c[4:3])
      2'h0: return FLT_80HZ;
      2'h2: return FLT_500HZ;
      2'h3: return FLT_1KHZ;
      default: return FLT_2KHZ;
    endcase
  endfunction : exp_flt

  initial begin
    void'($urandom(22));
    repeat (6) @(negedge clk);
    chk("oe_n_reset", 16'h0001, {15'h0000, oe_n});
    rst = 1'b0;
    @(negedge clk);
    chk("oe_n_run", 16'h0000, {15'h0000, oe_n});
    chk("field_ready", 16'h0001, {15'h0000, f_rdy});
    for (int k = 0; k < 14; k++) begin
      rd(4'(k));
      chk("reset_value", rst_exp[k], got);
    end
    // Reserved bits written with random values on purpose
    for (int k = 0; k < 8; k++) begin
      cfg = 10'($urandom);
      cfg[7:5] = FMT_ANALOG;
      cfg[9] = k[2];
      cfg[2:1] = k[1:0];
      cfg[4:3] = k[1:0];
      wr(IDX_CONFIG, {6'h00, cfg});
      wr(IDX_TC_GROUP, 16'(k[1:0]));
      wr(IDX_SLOPE, 16'(k * 3));
      wr(IDX_CURVE, 16'(k));
      rd(IDX_CONFIG);
      chk("config", {6'h00, cfg & CFG_KEEP_MASK}, got);
      chk("range", {13'h0000, exp_rng(cfg)}, {13'h0000, rng});
      chk("rng_red", {13'h0000, exp_rng(cfg) == RNG_15 ? RNG_30 : exp_rng(cfg)}, {13'h0000, rng_s});
      chk("filter", {14'h0000, exp_flt(cfg)}, {14'h0000, flt});
      chk("tc_group", 16'(k[1:0]), {14'h0000, grp});
      chk("slope", 16'(k * 3), {11'h000, slope});
      chk("curve", 16'(k), {13'h0000, curve});
    end
    wr(IDX_CLAMP_LO, 16'h01ff);
    rd(IDX_CLAMP_LO);
    chk("clamp_lo_sat", 16'h0100, {7'h00, got[8:0]});
    wr(IDX_CONFIG, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      g = 14'($urandom);
      o = 12'($urandom);
      lo = 9'($urandom_range(256));
      hi = 9'($urandom);
      f = 14'($urandom);
      if (k == 0) begin
        {g, f, o, lo, hi} = {14'h2000, 14'h2000, 12'h800, 9'h100, 9'h000};
      end
      wr(IDX_GAIN, 16'(g));
      wr(IDX_OFFSET, 16'(o));
      wr(IDX_CLAMP_LO, 16'(lo));
      wr(IDX_CLAMP_HI, 16'(hi));
      send(f);
      repeat (3) @(negedge clk);
      e = proc(f, g, o, lo, hi);
      chk("dac", {4'h0, e[13:2]}, {4'h0, dac});
      rd(IDX_READOUT);
      chk("readout", {2'h0, e}, got);
    end
    wr(IDX_GAIN, 16'h0800);
    wr(IDX_OFFSET, 16'h0200);
    wr(IDX_CLAMP_LO, 16'h0000);
    wr(IDX_CLAMP_HI, 16'h01ff);
    fval = 14'($urandom_range(8000)) - 14'hfa0;
    e = proc(fval, 14'h0800, 12'h200, 9'h000, 9'h1ff);
    fv = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CONFIG, {8'h00, k ? FMT_PWM_INV : FMT_PWM, 5'h00});
      repeat (3 * PER) @(negedge clk);
      chk("pwm_high", k ? PER - ((e[13:3] * PER) >> 11) : (e[13:3] * PER) >> 11, hi_t[15:0]);
      chk("pwm_period", 16'(PER), per_t[15:0]);
      rd(IDX_READOUT);
      chk("readout_pwm", 16'h0000, got);
    end
    fval = 14'($urandom);
    e = proc(fval, 14'h0800, 12'h200, 9'h000, 9'h1ff);
    wr(IDX_CONFIG, {8'h00, FMT_MUX_TRIG, 5'h00});
    for (int k = 0; k < 2; k++) begin
      want_hi = k[0];
      repeat (4 * REF) @(negedge clk);
      chk("mux_trig", k ? {4'h0, e[13:7], 5'h00} : {4'h0, e[6:0], 5'h00}, {4'h0, dac});
    end
    wr(IDX_CONFIG, {8'h00, FMT_MUX_CONT, 5'h00});
    wt = 0;
    while (dac !== {e[6:0], 5'h00} && wt < 200) begin
      @(negedge clk);
      wt++;
    end
    while (dac === {e[6:0], 5'h00} && wt < 400) begin
      @(negedge clk);
      wt++;
    end
    chk("mux_cont", {4'h0, e[13:7], 5'h00}, {4'h0, dac});
    wr(IDX_CONFIG, {8'h00, FMT_BURN, 5'h00});
    repeat (8) @(negedge clk);
    got = {4'h0, dac};
    repeat (64) @(negedge clk);
    chk("burn_ramp", 16'h0001, {15'h0000, dac > got[11:0]});
    fv = 1'b0;
    test_done();
  end

  initial begin
    #300000;
    mismatches++;
    test_done();
  end
endmodule : field_sensor_output_config_bench
`default_nettype wire
